//--- hdl/interrupt_ctrl_sw_watchdog.sv
// Interrupt controller with priority arbitration and software watchdog
// How it works
// - Eleven sources are arbitrated over four priority levels.
// - Request flags set on their condition whatever the enables say.
// - Flags sampled each machine cycle; samples polled for enabled requests.
// - At instruction end a detected request forces a call to its vector.
// - No acceptance while the instruction is a return or enable/priority write.
// - An active service is pre-empted only by a strictly higher level.
// - Return from service ends the highest active level.
// - Global enable bit 7 of enable register A blocks every source.
// - Enable register A bits 4..0 gate serial0, timer1, ext1, timer0, ext0.
// - Enable register B bits 5..1 gate external interrupts 6..2.
// - Enable register C bit 0 gates serial channel 1.
// - Timer control holds timer flags at 7 and 5, ext 1/0 at 3..0.
// - Polarity register bits 6 and 5 pick edge of ext 3 and 2.
// - Request register bits 5..1 hold edge flags of ext 6..2.
// - Timer overflow flags clear by the service ack pulse, edge flags on acceptance.
// - Seven external interrupt inputs come from other on-chip units.
// - Ext 5 and 6 are inverted ahead of rising-edge detection.
// - Watchdog is a 16-bit counter stepped every 24 or 384 clocks.
// - Reload bit 7 selects the slow prescaler; reload always readable.
// - Start bit runs the counter; at 7CFF status rises and asks reset.
// - Arm then start within 12 clocks reloads the high byte.
// - Six groups get a level from one bit in each priority register.
// - Each source has a fixed service vector address.
`timescale 1ns/100ps
`include "interrupt_ctrl_cfg.svh"
module interrupt_ctrl_sw_watchdog #(
  parameter int WINDOW_CYC = `WDT_WINDOW_CYC
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Special register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Instruction sequencer
  input wire logic cyc_tick,
  input wire logic instr_done,
  input wire logic cur_is_return_from_service,
  output logic call_req,
  output logic [15:0] call_vector,
  output logic timer0_service_ack,
  output logic timer1_service_ack,
  // Event sources
  input wire logic [6:0] ext_int_in,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic serial0_irq,
  input wire logic serial1_irq,
  // Watchdog reset request
  output logic watchdog_status
);

  // Registers
  logic [7:0] interrupt_enable_a_reg, interrupt_enable_b_reg, interrupt_enable_c_reg, ip0_reg, ip1_reg;
  logic [7:0] timer_ext_int_control_reg, ext_int_polarity_reg, watchdog_reload_reg;
  logic [4:0] ext_int_request_flags_reg;
  logic [6:0] ext_prev_reg;
  interrupt_ctrl_pkg::src_vec_t sample_reg;
  logic [3:0] in_service_reg;
  logic write_seen_reg;
  logic arm_reg, start_reg, running_reg;
  logic [3:0] arm_cnt_reg, start_cnt_reg;
  logic [8:0] presc_reg;
  logic [15:0] wdt_cnt_reg;
  logic [4:0] arm_age_reg;

  // Priority group of each source
  function automatic logic [2:0] group_of(input int idx);
    case (idx)
      0, 5: group_of = 3'h0;
      1, 6: group_of = 3'h1;
      2, 7: group_of = 3'h2;
      3, 8: group_of = 3'h3;
      4, 9: group_of = 3'h4;
      default: group_of = 3'h5;
    endcase
  endfunction : group_of

  // Vector address of each source
  function automatic logic [15:0] vector_of(input interrupt_ctrl_pkg::src_idx_t idx);
    case (idx)
      4'h0: vector_of = `VEC_EXT0;
      4'h1: vector_of = `VEC_TIMER0;
      4'h2: vector_of = `VEC_EXT1;
      4'h3: vector_of = `VEC_TIMER1;
      4'h4: vector_of = `VEC_SERIAL0;
      4'h5: vector_of = `VEC_SERIAL1;
      4'h6: vector_of = `VEC_EXT2;
      4'h7: vector_of = `VEC_EXT3;
      4'h8: vector_of = `VEC_EXT4;
      4'h9: vector_of = `VEC_EXT5;
      default: vector_of = `VEC_EXT6;
    endcase
  endfunction : vector_of

  // Highest active service level, with a flag for any active
  function automatic logic [2:0] top_level(input logic [3:0] act);
    logic [2:0] r;
    r = 3'h0;
    for (int lv = 0; lv < 4; lv++) begin
      if (act[lv]) begin
        r = {1'b1, lv[1:0]};
      end
    end
    return r;
  endfunction : top_level

  // Highest level wins; lower index wins inside a level
  function automatic logic [6:0] pick(input interrupt_ctrl_pkg::src_vec_t req,
                                      input logic [7:0] lo, input logic [7:0] hi);
    logic [6:0] r;
    logic [2:0] g;
    r = 7'h00;
    for (int lv = 0; lv < 4; lv++) begin
      for (int i = `NUM_SRC - 1; i >= 0; i--) begin
        g = group_of(i);
        if (req[i] && ({hi[g], lo[g]} == lv[1:0])) begin
          r = {1'b1, lv[1:0], i[3:0]};
        end
      end
    end
    return r;
  endfunction : pick

  // Address decode of writes
  wire wr_interrupt_enable_a = sfr_wr && (sfr_addr == `ADDR_INTERRUPT_ENABLE_A);
  wire wr_interrupt_enable_b = sfr_wr && (sfr_addr == `ADDR_INTERRUPT_ENABLE_B);
  wire wr_interrupt_enable_c = sfr_wr && (sfr_addr == `ADDR_INTERRUPT_ENABLE_C);
  wire wr_ip0 = sfr_wr && (sfr_addr == `ADDR_IP0);
  wire wr_ip1 = sfr_wr && (sfr_addr == `ADDR_IP1);
  wire wr_timer_ext_int_control = sfr_wr && (sfr_addr == `ADDR_TIMER_EXT_INT_CONTROL);
  wire wr_ext_int_polarity = sfr_wr && (sfr_addr == `ADDR_EXT_INT_POLARITY);
  wire wr_ext_int_request_flags = sfr_wr && (sfr_addr == `ADDR_EXT_INT_REQUEST_FLAGS);
  wire wr_watchdog_reload = sfr_wr && (sfr_addr == `ADDR_WATCHDOG_RELOAD);
  wire wr_int_cfg = wr_interrupt_enable_a | wr_interrupt_enable_b | wr_interrupt_enable_c | wr_ip0 | wr_ip1;

  // Edge detection; the two inverted inputs then look for a rising edge
  // inversion of ext 5 and 6
  wire [6:0] cond_in = {~ext_int_in[6:5], ext_int_in[4:0]};
  wire [6:0] rise = cond_in & ~ext_prev_reg;
  wire [6:0] fall = ~cond_in & ext_prev_reg;
  // polarity choice for ext 2 and 3
  wire edge2 = ext_int_polarity_reg[`BIT_EXT2_EDGE] ? rise[2] : fall[2];
  wire edge3 = ext_int_polarity_reg[`BIT_EXT3_EDGE] ? rise[3] : fall[3];
  wire [4:0] ext_hi_edge = {rise[6], rise[5], rise[4], edge3, edge2};

  // Arbitration over sampled flags and live enables
  // enable registers B, C and A gate
  wire [10:0] en_vec = {interrupt_enable_b_reg[5:1], interrupt_enable_c_reg[0], interrupt_enable_a_reg[4:0]};
  wire [10:0] req_vec = sample_reg & en_vec;
  wire [6:0] pick_res = pick(req_vec, ip0_reg, ip1_reg);
  wire found = pick_res[6];
  wire [1:0] sel_level = pick_res[5:4];
  wire [3:0] sel_idx = pick_res[3:0];
  wire [2:0] top = top_level(in_service_reg);
  // hold off on return or configuration write
  wire blocked = cur_is_return_from_service | write_seen_reg | wr_int_cfg;
  wire level_ok = !top[2] || (sel_level > top[1:0]);
  wire accept = instr_done && found && interrupt_enable_a_reg[`BIT_GLOBAL_EN] && !blocked && level_ok;
  wire [10:0] accept_hot = accept ? (11'h001 << sel_idx) : 11'h000;
  // return ends the highest active level
  wire return_from_service_done = instr_done && cur_is_return_from_service && top[2];
  wire [3:0] lvl_set = accept ? (4'h1 << sel_level) : 4'h0;
  wire [3:0] lvl_clr = return_from_service_done ? (4'h1 << top[1:0]) : 4'h0;

  // Request flags: hardware set wins over any clear in the same cycle
  // flags set regardless of enables
  // timer flags cleared by the ack pulse or a write
  wire tf1_next = timer1_ovf | (wr_timer_ext_int_control ? sfr_wdata[7] : timer_ext_int_control_reg[7] & ~timer1_service_ack);
  wire tf0_next = timer0_ovf | (wr_timer_ext_int_control ? sfr_wdata[5] : timer_ext_int_control_reg[5] & ~timer0_service_ack);
  wire ie1_edge = fall[1] | (wr_timer_ext_int_control ? sfr_wdata[3] : timer_ext_int_control_reg[3] & ~accept_hot[2]);
  wire ie0_edge = fall[0] | (wr_timer_ext_int_control ? sfr_wdata[1] : timer_ext_int_control_reg[1] & ~accept_hot[0]);
  // Level mode follows the pin, so a write cannot hide a held request
  wire ie1_next = timer_ext_int_control_reg[2] ? ie1_edge : ~ext_int_in[1];
  wire ie0_next = timer_ext_int_control_reg[0] ? ie0_edge : ~ext_int_in[0];
  wire [7:0] ctl_src = wr_timer_ext_int_control ? sfr_wdata : timer_ext_int_control_reg;
  wire [7:0] timer_ext_int_control_next = {tf1_next, ctl_src[6], tf0_next, ctl_src[4],
                          ie1_next, ctl_src[2], ie0_next, ctl_src[0]};
  logic [4:0] ext_int_request_flags_next;
  genvar k;
  for (k = 0; k < 5; k++) begin : g_iex
    assign ext_int_request_flags_next[k] = ext_hi_edge[k] |
      (wr_ext_int_request_flags ? sfr_wdata[k+1] : ext_int_request_flags_reg[k] & ~accept_hot[k+6]);
  end
  wire [10:0] flag_vec = {ext_int_request_flags_reg, serial1_irq, serial0_irq,
                          timer_ext_int_control_reg[7], timer_ext_int_control_reg[3], timer_ext_int_control_reg[5], timer_ext_int_control_reg[1]};

  // Watchdog control
  // prescaled 16-bit up-counter
  wire [8:0] presc_lim = watchdog_reload_reg[`BIT_PRESC_SEL] ? `WDT_DIV_SLOW : `WDT_DIV_FAST;
  wire presc_wrap = (presc_reg == presc_lim - 9'h001);
  wire start_wr = wr_interrupt_enable_b && sfr_wdata[`BIT_START];
  // refresh only inside the arm window
  wire refresh = start_wr && arm_reg;
  wire [3:0] win_last = WINDOW_CYC[3:0] - 4'h1;
  wire [15:0] wdt_next = refresh ? {1'b0, watchdog_reload_reg[6:0], 8'h00} :
                         (running_reg && presc_wrap) ? wdt_cnt_reg + 16'h0001 : wdt_cnt_reg;

  // Enable, priority and polarity registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_enable_a_reg <= `RST_BYTE;
      interrupt_enable_b_reg <= `RST_BYTE;
      interrupt_enable_c_reg <= `RST_BYTE;
      ip0_reg <= `RST_BYTE;
      ip1_reg <= `RST_BYTE;
      ext_int_polarity_reg <= `RST_BYTE;
      watchdog_reload_reg <= `RST_BYTE;
    end else if (clk_en) begin
      if (wr_interrupt_enable_a) interrupt_enable_a_reg <= sfr_wdata;
      if (wr_interrupt_enable_b) interrupt_enable_b_reg <= sfr_wdata;
      if (wr_interrupt_enable_c) interrupt_enable_c_reg <= sfr_wdata;
      if (wr_ip0) ip0_reg <= sfr_wdata;
      if (wr_ip1) ip1_reg <= sfr_wdata;
      if (wr_ext_int_polarity) ext_int_polarity_reg <= sfr_wdata;
      if (wr_watchdog_reload) watchdog_reload_reg <= sfr_wdata;
    end
  end

  // Flags, edge history and machine-cycle sample
  // sample once per machine cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_ext_int_control_reg <= `RST_BYTE;
      ext_int_request_flags_reg <= 5'h00;
      ext_prev_reg <= 7'h00;
      sample_reg <= 11'h000;
    end else if (clk_en) begin
      timer_ext_int_control_reg <= timer_ext_int_control_next;
      ext_int_request_flags_reg <= ext_int_request_flags_next;
      ext_prev_reg <= cond_in;
      // A taken source is dropped from the sample so it is not taken twice
      sample_reg <= cyc_tick ? flag_vec : (sample_reg & ~accept_hot);
    end
  end

  // Service state and sequencer outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_service_reg <= 4'h0;
      write_seen_reg <= 1'b0;
      call_req <= 1'b0;
      call_vector <= 16'h0000;
      timer0_service_ack <= 1'b0;
      timer1_service_ack <= 1'b0;
    end else if (clk_en) begin
      in_service_reg <= (in_service_reg & ~lvl_clr) | lvl_set;
      write_seen_reg <= !instr_done && (write_seen_reg || wr_int_cfg);
      call_req <= accept;
      if (accept) call_vector <= vector_of(sel_idx);
      // ack pulses on entry to a timer service
      timer0_service_ack <= accept && (sel_idx == 4'h1);
      timer1_service_ack <= accept && (sel_idx == 4'h3);
    end
  end

  // Watchdog counter; only reset stops it once started
  // arm and start bits self-clear after the window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_reg <= 1'b0;
      arm_cnt_reg <= 4'h0;
      start_reg <= 1'b0;
      start_cnt_reg <= 4'h0;
      running_reg <= 1'b0;
      presc_reg <= 9'h000;
      wdt_cnt_reg <= 16'h0000;
      watchdog_status <= 1'b0;
    end else if (clk_en) begin
      if (refresh || (arm_reg && arm_cnt_reg == win_last)) arm_reg <= 1'b0;
      else if (wr_interrupt_enable_a && sfr_wdata[`BIT_ARM]) arm_reg <= 1'b1;
      arm_cnt_reg <= arm_reg ? arm_cnt_reg + 4'h1 : 4'h0;
      if (start_reg && start_cnt_reg == win_last) start_reg <= 1'b0;
      else if (start_wr) start_reg <= 1'b1;
      start_cnt_reg <= start_reg ? start_cnt_reg + 4'h1 : 4'h0;
      if (start_wr) running_reg <= 1'b1;
      presc_reg <= (presc_wrap || !running_reg) ? 9'h000 : presc_reg + 9'h001;
      wdt_cnt_reg <= wdt_next;
      watchdog_status <= running_reg && (wdt_next == `WDT_TRIP);
    end
  end

  // Read back; unmapped addresses read as zero
  wire [7:0] rd_mux =
    (sfr_addr == `ADDR_INTERRUPT_ENABLE_A) ? {interrupt_enable_a_reg[7], arm_reg, 1'b0, interrupt_enable_a_reg[4:0]} :
    (sfr_addr == `ADDR_INTERRUPT_ENABLE_B) ? {interrupt_enable_b_reg[7], start_reg, interrupt_enable_b_reg[5:0]} :
    (sfr_addr == `ADDR_INTERRUPT_ENABLE_C) ? interrupt_enable_c_reg :
    (sfr_addr == `ADDR_IP0) ? {1'b0, watchdog_status, ip0_reg[5:0]} :
    (sfr_addr == `ADDR_IP1) ? {2'b00, ip1_reg[5:0]} :
    (sfr_addr == `ADDR_TIMER_EXT_INT_CONTROL) ? timer_ext_int_control_reg :
    (sfr_addr == `ADDR_EXT_INT_POLARITY) ? ext_int_polarity_reg :
    (sfr_addr == `ADDR_EXT_INT_REQUEST_FLAGS) ? {2'b00, ext_int_request_flags_reg, 1'b0} :
    (sfr_addr == `ADDR_WATCHDOG_RELOAD) ? watchdog_reload_reg : 8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) sfr_rdata <= 8'h00;
    else if (clk_en && sfr_rd) sfr_rdata <= rd_mux;
  end

  // Age of the arm bit, kept apart from the window counter so a slip there shows
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_age_reg <= 5'h00;
    end else if (clk_en) begin
      arm_age_reg <= arm_reg ? arm_age_reg + 5'h01 : 5'h00;
    end
  end

  // Checks
  sequence s_taken;
    accept ##1 call_req;
  endsequence
  a_global_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
    call_req |-> $past(interrupt_enable_a_reg[`BIT_GLOBAL_EN])) else $error("call while globally disabled");
  a_postpone_taking: assert property (@(posedge clk) disable iff (sys_rst)
    call_req |-> !$past(cur_is_return_from_service) && !$past(wr_int_cfg)) else $error("call not postponed");
  a_strict_preempt: assert property (@(posedge clk) disable iff (sys_rst)
    accept && top[2] |-> sel_level > top[1:0]) else $error("equal level preempted");
  a_vector_match: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    s_taken |-> call_vector == vector_of($past(sel_idx))) else $error("wrong vector");
  a_timer_ack_clear: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    accept && sel_idx == 4'h1 ##1 timer0_service_ack && !timer0_ovf && !wr_timer_ext_int_control
    |=> !timer_ext_int_control_reg[5]) else $error("timer0 flag not cleared by ack");
  a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    timer1_ovf |=> timer_ext_int_control_reg[7]) else $error("timer1 flag lost");
  a_arm_window: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    arm_reg |-> arm_age_reg < WINDOW_CYC[4:0]) else $error("arm stands too long");
  a_arm_lapse: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    $fell(arm_reg) && !$past(refresh) |-> arm_age_reg == WINDOW_CYC[4:0])
    else $error("arm window too short");
  a_refresh_load: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    refresh |=> wdt_cnt_reg == {1'b0, $past(watchdog_reload_reg[6:0]), 8'h00}) else $error("bad reload");
  a_wdt_trip: assert property (@(posedge clk) disable iff (sys_rst)
    watchdog_status |-> wdt_cnt_reg == `WDT_TRIP && running_reg) else $error("status off trip");
  a_return_from_service_level: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
    return_from_service_done && !accept |=> !in_service_reg[$past(top[1:0])]) else $error("level not ended");

endmodule : interrupt_ctrl_sw_watchdog

//--- hdl/interrupt_ctrl_cfg.svh
// Constant set of the interrupt controller and software watchdog
`ifndef INTERRUPT_CTRL_CFG_SVH
`define INTERRUPT_CTRL_CFG_SVH
// Register addresses on the special register port
`define ADDR_TIMER_EXT_INT_CONTROL 8'h88
`define ADDR_INTERRUPT_ENABLE_A 8'hA8
`define ADDR_INTERRUPT_ENABLE_B 8'hB8
`define ADDR_EXT_INT_REQUEST_FLAGS 8'hC0
`define ADDR_INTERRUPT_ENABLE_C 8'h9A
`define ADDR_IP0 8'hA9
`define ADDR_IP1 8'hB9
`define ADDR_WATCHDOG_RELOAD 8'h86
`define ADDR_EXT_INT_POLARITY 8'hC8
// Reset value of every register
`define RST_BYTE 8'h00
// Field positions
`define BIT_GLOBAL_EN 7
`define BIT_ARM 6
`define BIT_START 6
`define BIT_WDT_STATUS 6
`define BIT_PRESC_SEL 7
`define BIT_EXT2_EDGE 5
`define BIT_EXT3_EDGE 6
// Watchdog timing
`define WDT_WINDOW_CYC 12
`define WDT_DIV_FAST 9'h018
`define WDT_DIV_SLOW 9'h180
`define WDT_TRIP 16'h7CFF
// Number of sources and service vectors
`define NUM_SRC 11
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001B
`define VEC_SERIAL0 16'h0023
`define VEC_SERIAL1 16'h0083
`define VEC_EXT2 16'h004B
`define VEC_EXT3 16'h0053
`define VEC_EXT4 16'h005B
`define VEC_EXT5 16'h0063
`define VEC_EXT6 16'h006B
`endif

//--- hdl/interrupt_ctrl_pkg.sv
// Types shared by the interrupt controller
package interrupt_ctrl_pkg;
  typedef logic [3:0] src_idx_t;
  typedef logic [1:0] level_t;
  typedef logic [10:0] src_vec_t;
endpackage : interrupt_ctrl_pkg

//--- dv/seq_model.sv
// Behavioural instruction sequencer driving machine-cycle ticks and instruction ends
`timescale 1ns/100ps
module seq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pace select, high gives eight-clock instructions
  input wire logic slow,
  // Sequencer strobes
  output logic cyc_tick,
  output logic instr_done
);
  logic [2:0] phase_reg;
  // Strobes move on the falling edge so the design always samples them settled
  // one tick per machine cycle
  // instruction end marks the accept point
  always @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= 3'h0;
      cyc_tick <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      cyc_tick <= (phase_reg[1:0] == 2'h0);
      instr_done <= slow ? (phase_reg == 3'h7) : (phase_reg[1:0] == 2'h3); // Slow pace halves rate
    end
  end
endmodule : seq_model

//--- dv/testbench.sv
// Self-checking bench for the interrupt controller and software watchdog
`timescale 1ns/100ps
`include "interrupt_ctrl_cfg.svh"
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} reg_row_t;
  localparam logic [6:0] IDLE = 7'h6F; // Idle pin levels, only input 4 rests low
  localparam int STEP = 24;
  logic clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, cur_is_return_from_service = 1'b0;
  logic timer0_ovf = 1'b0, timer1_ovf = 1'b0, serial0_irq = 1'b0, serial1_irq = 1'b0;
  logic slow = 1'b0, clk_en = 1'b1, cyc_tick, instr_done, call_req;
  logic timer0_service_ack, timer1_service_ack;
  logic watchdog_status;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [6:0] ext_int_in = IDLE;
  logic [15:0] call_vector;
  logic [15:0] vec_tab [11];
  reg_row_t rows [9];
  int failures = 0, check_count = 0, n;
  always #10 clk = ~clk;
  seq_model u_seq (.clk(clk), .sys_rst(sys_rst), .slow(slow), .cyc_tick(cyc_tick),
    .instr_done(instr_done));
  interrupt_ctrl_sw_watchdog u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .cyc_tick(cyc_tick), .instr_done(instr_done),
    .cur_is_return_from_service(cur_is_return_from_service), .call_req(call_req), .call_vector(call_vector),
    .timer0_service_ack(timer0_service_ack), .timer1_service_ack(timer1_service_ack),
    .ext_int_in(ext_int_in), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
    .serial0_irq(serial0_irq), .serial1_irq(serial1_irq), .watchdog_status(watchdog_status));
  task automatic give_verdict();
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Register tasks start on a falling edge and leave an idle cycle behind
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK("sfr_rdata", sfr_rdata, exp)
    @(negedge clk);
  endtask : reg_rd
  // Level sources hold until released; timers take a one-cycle pulse
  task automatic set_src(input int i, input logic on);
    int p;
    p = (i == 0) ? 0 : (i == 2) ? 1 : i - 4;
    case (i)
      1: timer0_ovf = on;
      3: timer1_ovf = on;
      4: serial0_irq = on;
      5: serial1_irq = on;
      default: ext_int_in[p] = IDLE[p] ^ on;
    endcase
  endtask : set_src
  task automatic fire(input int i);
    set_src(i, 1'b1);
    @(negedge clk);
    if (i == 1 || i == 3) set_src(i, 1'b0);
  endtask : fire
  task automatic wait_call(input logic [15:0] v, input logic a0, input logic a1);
    n = 0;
    while (call_req !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    `CHK("call_req", call_req, 1'b1)
    `CHK("call_vector", call_vector, v)
    `CHK("timer0_ack", timer0_service_ack, a0)
    `CHK("timer1_ack", timer1_service_ack, a1)
  endtask : wait_call
  task automatic no_call(input int c);
    repeat (c) begin
      @(negedge clk);
      `CHK("no_call", call_req, 1'b0)
    end
  endtask : no_call
  task automatic return_from_service();
    cur_is_return_from_service = 1'b1;
    @(posedge clk);
    while (instr_done !== 1'b1) @(posedge clk);
    @(negedge clk);
    cur_is_return_from_service = 1'b0;
  endtask : return_from_service
  // Watchdog cuts a hang short, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    vec_tab = '{`VEC_EXT0, `VEC_TIMER0, `VEC_EXT1, `VEC_TIMER1, `VEC_SERIAL0, `VEC_SERIAL1,
      `VEC_EXT2, `VEC_EXT3, `VEC_EXT4, `VEC_EXT5, `VEC_EXT6};
    rows = '{'{`ADDR_INTERRUPT_ENABLE_A, 8'h3F, 8'h1F}, '{`ADDR_INTERRUPT_ENABLE_B, 8'h3E, 8'h3E},
      '{`ADDR_INTERRUPT_ENABLE_C, 8'h01, 8'h01}, '{`ADDR_IP0, 8'h3F, 8'h3F}, '{`ADDR_IP1, 8'hFF, 8'h3F},
      '{`ADDR_WATCHDOG_RELOAD, 8'hA5, 8'hA5}, '{`ADDR_EXT_INT_POLARITY, 8'h60, 8'h60},
      '{`ADDR_EXT_INT_REQUEST_FLAGS, 8'hFF, 8'h3E}, '{8'h55, 8'hFF, 8'h00}};
    repeat (16) @(negedge clk);
    `CHK("call_req", call_req, 1'b0)
    `CHK("watchdog_status", watchdog_status, 1'b0)
    sys_rst = 1'b0;
    @(negedge clk);
    // Reset value, write and read-back of each row
    foreach (rows[k]) begin
      reg_rd(rows[k].a, 8'h00);
      reg_wr(rows[k].a, rows[k].d);
      reg_rd(rows[k].a, rows[k].r);
    end
    foreach (rows[k]) reg_wr(rows[k].a, 8'h00);
    // Flag is raised with every enable off
    fire(3);
    reg_rd(`ADDR_TIMER_EXT_INT_CONTROL, 8'h80);
    reg_wr(`ADDR_TIMER_EXT_INT_CONTROL, 8'h00);
    // Global enable off blocks an enabled source until set
    reg_wr(`ADDR_INTERRUPT_ENABLE_A, 8'h1F);
    fire(1);
    no_call(40);
    reg_rd(`ADDR_TIMER_EXT_INT_CONTROL, 8'h20);
    reg_wr(`ADDR_INTERRUPT_ENABLE_A, 8'h9F);
    wait_call(`VEC_TIMER0, 1'b1, 1'b0);
    return_from_service();
    reg_rd(`ADDR_TIMER_EXT_INT_CONTROL, 8'h00);
    // Every source in turn, alternating instruction pace
    reg_wr(`ADDR_INTERRUPT_ENABLE_B, 8'h3E);
    reg_wr(`ADDR_INTERRUPT_ENABLE_C, 8'h01);
    for (int i = 0; i < 11; i++) begin
      slow = i[0];
      fire(i);
      wait_call(vec_tab[i], i == 1, i == 3);
      set_src(i, 1'b0);
      return_from_service();
      reg_rd(`ADDR_TIMER_EXT_INT_CONTROL, 8'h00);
      reg_rd(`ADDR_EXT_INT_REQUEST_FLAGS, 8'h00);
    end
    slow = 1'b0;
    // Equal level: fixed order, no pre-emption until return
    set_src(0, 1'b1);
    set_src(3, 1'b1);
    @(negedge clk);
    set_src(3, 1'b0);
    wait_call(`VEC_EXT0, 1'b0, 1'b0);
    set_src(0, 1'b0);
    no_call(40);
    return_from_service();
    wait_call(`VEC_TIMER1, 1'b0, 1'b1);
    return_from_service();
    // Group five at level three pre-empts a level zero service
    reg_wr(`ADDR_IP0, 8'h20);
    reg_wr(`ADDR_IP1, 8'h20);
    fire(1);
    wait_call(`VEC_TIMER0, 1'b1, 1'b0);
    fire(10);
    wait_call(`VEC_EXT6, 1'b0, 1'b0);
    set_src(10, 1'b0);
    return_from_service();
    return_from_service();
    reg_wr(`ADDR_IP0, 8'h00);
    reg_wr(`ADDR_IP1, 8'h00);
    // Edge mode on external interrupt 0: flag cleared on acceptance, type bits stand
    reg_wr(`ADDR_TIMER_EXT_INT_CONTROL, 8'h05);
    fire(0);
    wait_call(`VEC_EXT0, 1'b0, 1'b0);
    set_src(0, 1'b0);
    return_from_service();
    reg_rd(`ADDR_TIMER_EXT_INT_CONTROL, 8'h05);
    // Watchdog start, then arm and refresh to a high byte just below the trip count
    reg_wr(`ADDR_INTERRUPT_ENABLE_B, 8'h40);
    reg_wr(`ADDR_WATCHDOG_RELOAD, 8'h7C);
    // An arm with no start behind it lapses after the window
    reg_wr(`ADDR_INTERRUPT_ENABLE_A, 8'h40);
    repeat (14) @(negedge clk);
    reg_rd(`ADDR_INTERRUPT_ENABLE_A, 8'h00);
    reg_wr(`ADDR_INTERRUPT_ENABLE_A, 8'h40);
    reg_rd(`ADDR_INTERRUPT_ENABLE_A, 8'h40);
    reg_wr(`ADDR_INTERRUPT_ENABLE_B, 8'h40);
    reg_rd(`ADDR_INTERRUPT_ENABLE_B, 8'h40);
    repeat (20) @(negedge clk);
    reg_rd(`ADDR_INTERRUPT_ENABLE_A, 8'h00);
    reg_rd(`ADDR_INTERRUPT_ENABLE_B, 8'h00);
    reg_rd(`ADDR_WATCHDOG_RELOAD, 8'h7C);
    repeat (254 * STEP - 40) @(negedge clk);
    `CHK("watchdog_status", watchdog_status, 1'b0)
    n = 0;
    while (watchdog_status !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    `CHK("watchdog_status", watchdog_status, 1'b1)
    reg_rd(`ADDR_IP0, 8'h40);
    repeat (STEP) @(negedge clk);
    `CHK("watchdog_status", watchdog_status, 1'b0)
    // A write while the clock enable is low is not taken
    clk_en = 1'b0;
    reg_wr(`ADDR_INTERRUPT_ENABLE_C, 8'h00);
    clk_en = 1'b1;
    reg_rd(`ADDR_INTERRUPT_ENABLE_C, 8'h01);
    // A second reset is the only way to stop the watchdog
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    reg_rd(`ADDR_INTERRUPT_ENABLE_B, 8'h00);
    reg_rd(`ADDR_WATCHDOG_RELOAD, 8'h00);
    give_verdict();
  end
endmodule : testbench
